/* File: hw/dmcsa_arbiter.v */
// data memory bus arbiter with cycle stealing for host and aux I/O
// assumes all requesters are logic on mclk_i and hold requests until granted
`timescale 1ns/1ps
`include "dmcsa_defs.vh"
module dmcsa_arbiter (
  // clock and reset
  input  wire                  mclk_i,
  input  wire                  rst_b_i,
  // aux input port stream
  input  wire [`DMCSA_DW-1:0]  aux_data_i,
  input  wire                  aux_valid_i,
  output wire                  aux_ready_o,
  // I/O transfer setup
  input  wire                  io_start_i,
  input  wire [`DMCSA_AW-1:0]  io_base_i,
  input  wire [`DMCSA_AW-1:0]  io_throttle_i,
  output reg                   io_enable_o,
  output reg                   io_done_o,
  // host output transfers
  input  wire                  host_rd_req_i,
  input  wire [`DMCSA_AW-1:0]  host_addr_i,
  output reg                   host_rd_gnt_o,
  // control processor accesses from the service routine
  input  wire                  cp_dm_req_i,
  input  wire                  cp_we_i,
  input  wire [`DMCSA_AW-1:0]  cp_addr_i,
  input  wire [`DMCSA_DW-1:0]  cp_wdata_i,
  output reg                   cp_dm_gnt_o,
  // pipeline and its command buffer
  input  wire                  cab_empty_i,
  input  wire                  pipe_we_i,
  input  wire [`DMCSA_AW-1:0]  pipe_addr_i,
  input  wire [`DMCSA_DW-1:0]  pipe_wdata_i,
  output reg                   pipe_step_o,
  output reg                   pipe_stall_o,
  output reg  [`DMCSA_AW-1:0]  pipe_op_o,
  // data memory port
  output reg                   dm_en_o,
  output reg                   dm_we_o,
  output reg  [`DMCSA_AW-1:0]  dm_addr_o,
  output reg  [`DMCSA_DW-1:0]  dm_wdata_o,
  output reg  [1:0]            dm_owner_o
);

  // machine cycle divider
  reg  [`DMCSA_DIV_W-1:0] div_q;       // clock count within machine cycle
  wire                    mcyc_en;     // last clock of a machine cycle

  // aux transfer engine
  reg  [1:0]              aux_st_q;    // aux state
  reg  [1:0]              aux_wait_q;  // extra cycles waited for the bus
  reg  [`DMCSA_AW-1:0]    io_addr_q;   // next aux destination
  reg  [`DMCSA_AW-1:0]    thr_q;       // throttle count, counts up to zero
  wire [`DMCSA_DW-1:0]    fifo_data;   // registered head word
  wire                    fifo_valid;  // a word waits
  wire                    fifo_pop;    // take a word

  // control processor two-cycle access
  reg                     cp_hold_q;   // second stolen cycle pending
  reg                     cp_we_q;     // latched access
  reg  [`DMCSA_AW-1:0]    cp_addr_q;
  reg  [`DMCSA_DW-1:0]    cp_wdata_q;

  // owner decision
  reg  [1:0]              own_d;
  reg                     use_d;       // someone uses the bus
  wire                    aux_want;
  wire                    aux_force;
  wire                    aux_near;    // aux has already lost one cycle
  wire                    io_xfer;     // counted I/O transfer this cycle
  wire [`DMCSA_AW-1:0]    thr_inc;

  // divider: one enable every machine cycle
  assign mcyc_en = (div_q == `DMCSA_DIV_LAST);
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      div_q <= {`DMCSA_DIV_W{1'b0}};
    end else begin
      div_q <= div_q + 1'b1;  // wraps at sixteen clocks
    end
  end

  // aux words queue here; a full queue pushes back on the source
  dmcsa_fifo #(
    .WIDTH (`DMCSA_DW),
    .DEPTH (`DMCSA_FIFO_DEPTH),
    .AW    (`DMCSA_FIFO_AW)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .wr_data_i  (aux_data_i),
    .wr_valid_i (aux_valid_i),
    .wr_ready_o (aux_ready_o),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop)
  );

  // fetch a word only while I/O is enabled and the engine is free
  assign fifo_pop  = mcyc_en && io_enable_o && (aux_st_q == `DMCSA_AUX_IDLE);
  assign aux_want  = (aux_st_q == `DMCSA_AUX_REQ);
  // after two lost cycles the aux write overrides other users
  assign aux_force = aux_want && (aux_wait_q == `DMCSA_AUX_MAXW);
  // a cp access started now would hold the bus through the forced slot
  assign aux_near  = aux_want && (aux_wait_q == `DMCSA_ONE2);

  // bus owner for this machine cycle
  always @* begin
    own_d = `DMCSA_OWN_PIPE;
    use_d = 1'b1;
    if (cp_hold_q) begin
      own_d = `DMCSA_OWN_CP;    // second half of a cp access
    end else if (aux_force) begin
      own_d = `DMCSA_OWN_AUX;   // bounded wait
    end else if (host_rd_req_i) begin
      own_d = `DMCSA_OWN_HOST;  // host first
    end else if (cp_dm_req_i && !aux_near) begin  // cp deferred so aux waits two at most
      own_d = `DMCSA_OWN_CP;    // control processor second
    end else if (aux_want) begin
      own_d = `DMCSA_OWN_AUX;   // aux only when bus is free
    end else if (cab_empty_i) begin
      use_d = 1'b0;             // nothing queued, pipeline idles
    end
  end

  // an I/O transfer is any host read or aux write while enabled
  assign io_xfer = mcyc_en && io_enable_o &&
                   ((own_d == `DMCSA_OWN_HOST) || (own_d == `DMCSA_OWN_AUX));
  assign thr_inc = thr_q + `DMCSA_ONE16;

  // aux transfer: fetch, set up, write; three cycles when not held off
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      aux_st_q   <= `DMCSA_AUX_IDLE;
      aux_wait_q <= `DMCSA_ZERO2;
    end else if (mcyc_en) begin
      case (aux_st_q)
        `DMCSA_AUX_IDLE: begin
          if (fifo_valid && io_enable_o) begin
            aux_st_q <= `DMCSA_AUX_SETUP;  // word fetched
          end
        end
        `DMCSA_AUX_SETUP: begin
          aux_st_q   <= `DMCSA_AUX_REQ;
          aux_wait_q <= `DMCSA_ZERO2;
        end
        `DMCSA_AUX_REQ: begin
          if (own_d == `DMCSA_OWN_AUX) begin
            aux_st_q <= `DMCSA_AUX_IDLE;   // written, one stolen cycle
          end else begin
            aux_wait_q <= aux_wait_q + `DMCSA_ONE2;  // held off
          end
        end
        default: begin
          aux_st_q <= `DMCSA_AUX_IDLE;
        end
      endcase
    end
  end

  // I/O enable, destination address and throttle
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      io_enable_o <= 1'b0;
      io_done_o   <= 1'b0;
      io_addr_q   <= `DMCSA_ZERO16;
      thr_q       <= `DMCSA_ZERO16;
    end else begin
      io_done_o <= 1'b0;
      if (io_start_i) begin
        // count loads negated so it ends at zero
        io_enable_o <= (io_throttle_i != `DMCSA_ZERO16);
        io_addr_q   <= io_base_i;
        thr_q       <= `DMCSA_ZERO16 - io_throttle_i;
      end else if (io_xfer) begin
        thr_q <= thr_inc;
        if (own_d == `DMCSA_OWN_AUX) begin
          io_addr_q <= io_addr_q + `DMCSA_ONE16;
        end
        if (thr_inc == `DMCSA_ZERO16) begin
          io_enable_o <= 1'b0;  // stop I/O and interrupt
          io_done_o   <= 1'b1;
        end
      end
    end
  end

  // control processor access holds the bus for two machine cycles
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cp_hold_q  <= 1'b0;
      cp_we_q    <= 1'b0;
      cp_addr_q  <= `DMCSA_ZERO16;
      cp_wdata_q <= {`DMCSA_DW{1'b0}};
    end else if (mcyc_en) begin
      if (cp_hold_q) begin
        cp_hold_q <= 1'b0;  // second cycle done
      end else if (own_d == `DMCSA_OWN_CP) begin
        cp_hold_q  <= 1'b1;  // first of two cycles
        cp_we_q    <= cp_we_i;
        cp_addr_q  <= cp_addr_i;
        cp_wdata_q <= cp_wdata_i;
      end
    end
  end

  // memory port and pipeline step, registered at each machine cycle
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dm_en_o       <= 1'b0;
      dm_we_o       <= 1'b0;
      dm_addr_o     <= `DMCSA_ZERO16;
      dm_wdata_o    <= {`DMCSA_DW{1'b0}};
      dm_owner_o    <= `DMCSA_OWN_PIPE;
      host_rd_gnt_o <= 1'b0;
      cp_dm_gnt_o   <= 1'b0;
      pipe_step_o   <= 1'b0;
      pipe_stall_o  <= 1'b0;
      pipe_op_o     <= `DMCSA_ZERO16;
    end else begin
      // grants and step last one clock
      host_rd_gnt_o <= 1'b0;
      cp_dm_gnt_o   <= 1'b0;
      pipe_step_o   <= 1'b0;
      if (mcyc_en) begin
        dm_en_o    <= use_d;
        dm_owner_o <= own_d;
        case (own_d)
          `DMCSA_OWN_HOST: begin
            dm_we_o       <= 1'b0;          // read out to host
            dm_addr_o     <= host_addr_i;
            host_rd_gnt_o <= 1'b1;
          end
          `DMCSA_OWN_CP: begin
            // the first cycle only reserves the bus; the access lands on the second
            dm_we_o     <= cp_hold_q && cp_we_q;
            dm_addr_o   <= cp_hold_q ? cp_addr_q : cp_addr_i;
            dm_wdata_o  <= cp_wdata_q;
            cp_dm_gnt_o <= cp_hold_q;
          end
          `DMCSA_OWN_AUX: begin
            dm_we_o    <= 1'b1;             // aux word into memory
            dm_addr_o  <= io_addr_q;
            dm_wdata_o <= fifo_data;
          end
          default: begin
            dm_we_o    <= use_d && pipe_we_i;
            dm_addr_o  <= pipe_addr_i;
            dm_wdata_o <= pipe_wdata_i;
          end
        endcase
        // pipeline runs whenever it owns the bus and has commands
        if ((own_d == `DMCSA_OWN_PIPE) && use_d) begin
          pipe_step_o  <= 1'b1;
          pipe_stall_o <= 1'b0;
          pipe_op_o    <= pipe_op_o + `DMCSA_ONE16;  // only advances on a real step
        end else begin
          pipe_stall_o <= 1'b1;  // stolen or starved, op index kept
        end
      end
    end
  end
endmodule // dmcsa_arbiter

/* File: hw/dmcsa_defs.vh */
// constants for the data memory cycle-steal arbiter
// assumes one 100 MHz clock; the machine cycle is a divided enable
`ifndef DMCSA_DEFS_VH
`define DMCSA_DEFS_VH

// timing
`define DMCSA_CLK_NS        10
`define DMCSA_MCYC_NS       160
`define DMCSA_MCYC_CLKS     (`DMCSA_MCYC_NS / `DMCSA_CLK_NS)
`define DMCSA_DIV_W         4
`define DMCSA_DIV_LAST      4'hf

// widths
`define DMCSA_DW            24
`define DMCSA_AW            16
`define DMCSA_FIFO_DEPTH    8
`define DMCSA_FIFO_AW       3

// bus owner codes
`define DMCSA_OWN_PIPE      2'h0
`define DMCSA_OWN_HOST      2'h1
`define DMCSA_OWN_CP        2'h2
`define DMCSA_OWN_AUX       2'h3

// aux transfer states
`define DMCSA_AUX_IDLE      2'h0
`define DMCSA_AUX_SETUP     2'h1
`define DMCSA_AUX_REQ       2'h2

// aux extra waits, control processor access length
`define DMCSA_AUX_MAXW      2'h2
`define DMCSA_CP_CYCLES     2'h2
`define DMCSA_ONE2          2'h1
`define DMCSA_ZERO2         2'h0
`define DMCSA_ONE16         16'h0001
`define DMCSA_ZERO16        16'h0000

`endif

/* File: hw/dmcsa_fifo.v */
// small synchronous fifo for aux input words
// assumes writer and reader on the same clock; read data is registered
`timescale 1ns/1ps
module dmcsa_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             mclk_i,
  input  wire             rst_b_i,
  // fill side
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire             wr_valid_i,
  output wire             wr_ready_o,
  // drain side
  output reg  [WIDTH-1:0] rd_data_o,
  output wire             rd_valid_o,
  input  wire             rd_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // storage
  reg [AW:0]      wptr_q;             // write pointer, extra wrap bit
  reg [AW:0]      rptr_q;             // read pointer, extra wrap bit
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // wrap bit differs and index equal means full
  assign full       = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign empty      = (wptr_q == rptr_q);
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign push       = wr_valid_i && !full;
  assign pop        = rd_ready_i && !empty;

  // pointers; data of a pop appears on rd_data_o one clock later
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      wptr_q    <= {(AW+1){1'b0}};
      rptr_q    <= {(AW+1){1'b0}};
      rd_data_o <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wptr_q[AW-1:0]] <= wr_data_i;
        wptr_q                <= wptr_q + 1'b1;
      end
      if (pop) begin
        rd_data_o <= mem_q[rptr_q[AW-1:0]];
        rptr_q    <= rptr_q + 1'b1;
      end
    end
  end
endmodule // dmcsa_fifo

/* File: sim/dmcsa_arbiter_props.sv */
// port-level checks on the cycle-steal arbiter
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "dmcsa_defs.vh"
module dmcsa_arbiter_props (
  // clock and reset
  input wire        mclk_i,
  input wire        rst_b_i,
  // watched inputs
  input wire        cab_empty_i,
  input wire [15:0] host_addr_i,
  // watched outputs
  input wire        host_rd_gnt_o,
  input wire        cp_dm_gnt_o,
  input wire        io_enable_o,
  input wire        io_done_o,
  input wire        pipe_step_o,
  input wire        pipe_stall_o,
  input wire [15:0] pipe_op_o,
  input wire        dm_en_o,
  input wire        dm_we_o,
  input wire [15:0] dm_addr_o,
  input wire [1:0]  dm_owner_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // a host read takes the bus and costs the pipeline its cycle
  a_host_steal: assert property (host_rd_gnt_o |-> dm_owner_o == `DMCSA_OWN_HOST && !dm_we_o && pipe_stall_o && !pipe_step_o) else $error("host read did not steal");
  a_host_addr: assert property (host_rd_gnt_o |-> dm_addr_o == $past(host_addr_i)) else $error("host address wrong");
  a_aux_steal: assert property (dm_en_o && dm_owner_o == `DMCSA_OWN_AUX |-> dm_we_o && pipe_stall_o && !pipe_step_o) else $error("aux write did not steal");
  // grant comes only after two cycles both owned by the processor
  a_cp_two: assert property (cp_dm_gnt_o |-> dm_owner_o == `DMCSA_OWN_CP && $past(dm_owner_o) == `DMCSA_OWN_CP && !$past(dm_we_o)) else $error("cp access not two cycles");
  a_empty_halt: assert property (pipe_step_o |-> !$past(cab_empty_i)) else $error("step with empty buffer");
  a_step_owner: assert property (pipe_step_o |-> dm_owner_o == `DMCSA_OWN_PIPE && dm_en_o) else $error("step without bus");
  a_op_advance: assert property (pipe_step_o |-> pipe_op_o == $past(pipe_op_o) + `DMCSA_ONE16) else $error("step skipped work");
  a_op_hold: assert property (!pipe_step_o |-> $stable(pipe_op_o)) else $error("op moved without step");
  a_done_ends: assert property (io_done_o |-> !io_enable_o && $past(io_enable_o)) else $error("done without disable");
  a_done_pulse: assert property (io_done_o |=> !io_done_o) else $error("done not a pulse");
endmodule // dmcsa_arbiter_props

bind dmcsa_arbiter dmcsa_arbiter_props u_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cab_empty_i(cab_empty_i),
  .host_addr_i(host_addr_i), .host_rd_gnt_o(host_rd_gnt_o), .cp_dm_gnt_o(cp_dm_gnt_o), .io_enable_o(io_enable_o),
  .io_done_o(io_done_o), .pipe_step_o(pipe_step_o), .pipe_stall_o(pipe_stall_o), .pipe_op_o(pipe_op_o),
  .dm_en_o(dm_en_o), .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o), .dm_owner_o(dm_owner_o));

/* File: sim/dmcsa_aux_src.sv */
// aux input source offering words on a valid/ready stream
// assumes push is called just after a rising clock edge
`timescale 1ns/1ps
module dmcsa_aux_src (
  // clock
  input  wire        mclk_i,
  // stream toward the unit
  output reg  [23:0] aux_data_o,
  output reg         aux_valid_o,
  input  wire        aux_ready_i
);
  integer k; // bounded wait count
  reg     r; // ready as the coming edge sees it
  initial begin
    aux_data_o  = 24'h000000;
    aux_valid_o = 1'b0;
  end
  // hold word until ready is taken at an edge; a stuck sink gives up and says so
  task push(input [23:0] w, output ok);
    begin
      aux_data_o  = w;
      aux_valid_o = 1'b1;
      k = 0;
      do begin
        @(negedge mclk_i);
        r = aux_ready_i; // settled here; only a rising edge moves it
        @(posedge mclk_i);
        k = k + 1;
      end while (r !== 1'b1 && k < 100);
      ok = (r === 1'b1);
      #1;
      aux_valid_o = 1'b0;
      aux_data_o  = ~w; // released lines never show the old word
    end
  endtask
endmodule // dmcsa_aux_src

/* File: sim/test_data_memory_cycle_steal_arbiter.sv */
// scenario bench for the cycle-steal arbiter
// assumes the aux source model and a 100 MHz clock
`timescale 1ns/1ps
`include "dmcsa_defs.vh"
module test_data_memory_cycle_steal_arbiter;
  reg         mclk_i, rst_b_i, io_start_i, host_rd_req_i, cp_dm_req_i, cp_we_i, cab_empty_i, pipe_we_i;
  reg  [15:0] io_base_i, io_throttle_i, host_addr_i, cp_addr_i, pipe_addr_i, op0;
  reg  [23:0] cp_wdata_i, pipe_wdata_i;
  reg         ok; // aux source got its word taken
  wire [23:0] aux_data_i, dm_wdata_o;
  wire        aux_valid_i, aux_ready_o, io_enable_o, io_done_o, host_rd_gnt_o, cp_dm_gnt_o;
  wire        pipe_step_o, pipe_stall_o, dm_en_o, dm_we_o;
  wire [15:0] pipe_op_o, dm_addr_o;
  wire [1:0]  dm_owner_o;
  integer     n_mismatch, checked, cyc, t0, i;
  dmcsa_aux_src src (.mclk_i(mclk_i), .aux_data_o(aux_data_i), .aux_valid_o(aux_valid_i), .aux_ready_i(aux_ready_o));
  dmcsa_arbiter uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .aux_data_i(aux_data_i), .aux_valid_i(aux_valid_i),
    .aux_ready_o(aux_ready_o), .io_start_i(io_start_i), .io_base_i(io_base_i), .io_throttle_i(io_throttle_i),
    .io_enable_o(io_enable_o), .io_done_o(io_done_o), .host_rd_req_i(host_rd_req_i), .host_addr_i(host_addr_i),
    .host_rd_gnt_o(host_rd_gnt_o), .cp_dm_req_i(cp_dm_req_i), .cp_we_i(cp_we_i), .cp_addr_i(cp_addr_i),
    .cp_wdata_i(cp_wdata_i), .cp_dm_gnt_o(cp_dm_gnt_o), .cab_empty_i(cab_empty_i), .pipe_we_i(pipe_we_i),
    .pipe_addr_i(pipe_addr_i), .pipe_wdata_i(pipe_wdata_i), .pipe_step_o(pipe_step_o), .pipe_stall_o(pipe_stall_o),
    .pipe_op_o(pipe_op_o), .dm_en_o(dm_en_o), .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o),
    .dm_owner_o(dm_owner_o));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 1; // clock count for cycle-exact checks
  task tick(input integer n); repeat (n) begin @(posedge mclk_i); #1; end endtask
  task at(input integer n); while (cyc < t0 + n) tick(1); endtask
  task fail; begin $display("[FAIL] %0t mismatch", $time); n_mismatch = n_mismatch + 1; end endtask
  task cmp_bit(input a, input e); begin checked = checked + 1; if (a !== e) fail; end endtask
  task cmp_own(input [1:0] a, input [1:0] e); begin checked = checked + 1; if (a !== e) fail; end endtask
  task cmp_w(input [23:0] a, input [23:0] e); begin checked = checked + 1; if (a !== e) fail; end endtask
  task final_report;
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait on one pulse: 0 host grant, 1 cp grant, 2 io done, 3 pipeline step
  function pick(input [1:0] s); pick = s == 0 ? host_rd_gnt_o : s == 1 ? cp_dm_gnt_o : s == 2 ? io_done_o : pipe_step_o; endfunction
  task wait_hi(input [1:0] s);
    begin
      i = 0;
      while (pick(s) !== 1'b1 && i < 1000) begin tick(1); i = i + 1; end
      if (i == 1000) begin fail; final_report; end
      else begin t0 = cyc; op0 = pipe_op_o; end
    end
  endtask
  task io_go(input [15:0] n); begin io_base_i = 16'h0200; io_throttle_i = n; io_start_i = 1'b1; tick(1); io_start_i = 1'b0; end endtask
  // aux word into the queue; a queue that never takes it ends the run
  task send(input [23:0] w); begin src.push(w, ok); if (!ok) begin fail; final_report; end end endtask
  // free bus: the aux word lands at the third machine cycle
  task t_aux_plain; begin
    wait_hi(2'h3); send(24'h5a5a01);
    at(32); cmp_own(dm_owner_o, `DMCSA_OWN_PIPE); cmp_w(pipe_op_o, op0 + 16'h0002);
    cmp_w(dm_addr_o, 16'h0300); cmp_bit(dm_we_o, 1'b1);
    at(48); cmp_own(dm_owner_o, `DMCSA_OWN_AUX); cmp_w(dm_wdata_o, 24'h5a5a01);
    cmp_w(dm_addr_o, 16'h0200); cmp_bit(pipe_stall_o, 1'b1);
    at(64); cmp_w(pipe_op_o, op0 + 16'h0003);
  end endtask
  // host keeps the bus: aux ranks below it but waits two cycles at most
  task t_aux_held; begin
    wait_hi(2'h3); host_addr_i = 16'h0040; host_rd_req_i = 1'b1; send(24'h5a5a02);
    at(16); cmp_own(dm_owner_o, `DMCSA_OWN_HOST); cmp_w(dm_addr_o, 16'h0040);
    cmp_bit(pipe_stall_o, 1'b1); cmp_bit(dm_we_o, 1'b0);
    at(64); cmp_own(dm_owner_o, `DMCSA_OWN_HOST);
    at(80); cmp_own(dm_owner_o, `DMCSA_OWN_AUX);
    tick(1); wait_hi(2'h0); host_rd_req_i = 1'b0;
  end endtask
  // processor access: two stolen cycles, read then write
  task t_cp; begin
    wait_hi(2'h3); cp_we_i = 1'b1; cp_addr_i = 16'h0123; cp_wdata_i = 24'h00beef; cp_dm_req_i = 1'b1;
    at(16); cmp_own(dm_owner_o, `DMCSA_OWN_CP); cmp_bit(dm_we_o, 1'b0);
    at(32); cmp_bit(dm_we_o, 1'b1); cmp_w(dm_wdata_o, 24'h00beef); cmp_w(dm_addr_o, 16'h0123);
    cmp_bit(cp_dm_gnt_o, 1'b1); cp_dm_req_i = 1'b0;
    at(48); cmp_w(pipe_op_o, op0 + 16'h0001);
  end endtask
  // empty command buffer halts the pipeline, refill resumes it
  task t_empty; begin
    wait_hi(2'h3); cab_empty_i = 1'b1;
    at(64); cmp_w(pipe_op_o, op0); cmp_bit(dm_en_o, 1'b0);
    cab_empty_i = 1'b0;
    at(80); cmp_w(pipe_op_o, op0 + 16'h0001);
  end endtask
  // fill the fifo while disabled, then drain it under a throttle of 8
  task t_fifo; begin
    io_go(16'h0000); cmp_bit(io_enable_o, 1'b0);
    for (i = 0; i < 8; i = i + 1) begin send({16'h00a0, i[7:0]}); tick(1); end
    cmp_bit(aux_ready_o, 1'b0);
    io_go(16'h0008); wait_hi(2'h2);
    cmp_w(dm_addr_o, 16'h0207); cmp_w(dm_wdata_o, 24'h00a007);
    tick(1);
    cmp_bit(io_enable_o, 1'b0); cmp_bit(aux_ready_o, 1'b1);
  end endtask
  initial begin
    n_mismatch = 0; checked = 0; cyc = 0; rst_b_i = 1'b0; io_start_i = 1'b0; host_rd_req_i = 1'b0;
    cp_dm_req_i = 1'b0; cp_we_i = 1'b0; cab_empty_i = 1'b0; pipe_we_i = 1'b1; io_base_i = 16'h0000;
    io_throttle_i = 16'h0000; host_addr_i = 16'h0000; cp_addr_i = 16'h0000; pipe_addr_i = 16'h0300;
    cp_wdata_i = 24'h000000; pipe_wdata_i = 24'h00c0de; t0 = 0; op0 = 16'h0000;
    tick(20); rst_b_i = 1'b1;
    io_go(16'h00ff); cmp_bit(io_enable_o, 1'b1);
    t_aux_plain; t_aux_held; t_cp; t_empty; t_fifo;
    final_report;
  end
endmodule // test_data_memory_cycle_steal_arbiter
